// [logic/lbsc_pkg.sv]
// Constants, types and helper functions shared by the LED bypass command decoder
package lbsc_pkg;

    // ------------------------------------------------------------
    // Addresses and commands
    // ------------------------------------------------------------
    localparam logic [2:0]  SC_ADDR_PREFIX  = 3'h5;
    localparam logic [2:0]  ARA_REPLY_PFX   = 3'h2;
    localparam logic [7:0]  BC_WRITE_ADDR   = 8'h18;
    localparam logic [7:0]  BC_READ_ADDR    = 8'h19;
    localparam logic [7:0]  CRC_POLY        = 8'h07;

    // ------------------------------------------------------------
    // Command byte and mode register fields
    // ------------------------------------------------------------
    localparam int          CMD_LONG_BIT    = 7;
    localparam int          MR_OPEN_THR     = 15;
    localparam int          MR_SHORT_THR    = 14;
    localparam int          MR_FADE_HI      = 13;
    localparam int          MR_FADE_LO      = 11;
    localparam int          MR_ASYNC_ON     = 9;
    localparam int          MR_ASYNC_EN     = 8;
    localparam logic [15:0] MR_RESET        = 16'h8000;
    localparam logic [2:0]  SHORT_PEC_IDX   = 3'h2;
    localparam logic [2:0]  LONG_PEC_IDX    = 3'h3;
    localparam logic [1:0]  READ_LAST_IDX   = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          PWM_CYCLE_CLKS  = 2048;
    localparam logic [10:0] PWM_CNT_LAST    = 11'(PWM_CYCLE_CLKS - 1);

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_RX      = 3'h1,
        ST_ACK     = 3'h3,
        ST_ACKHOLD = 3'h2,
        ST_TX      = 3'h6,
        ST_TXACK   = 3'h7,
        ST_IGNORE  = 3'h5
    } lbsc_state_e;

    typedef enum logic [1:0] {
        K_SC_WR = 2'h0,
        K_SC_RD = 2'h1,
        K_BC_WR = 2'h2,
        K_BC_RD = 2'h3
    } lbsc_kind_e;

    function automatic logic [7:0] lbsc_crc8(input logic [7:0] crc_in, input logic [7:0] data);
        logic [7:0] c;
        c = crc_in ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    function automatic logic [4:0] lbsc_fade_mult(input logic [2:0] code);
        case (code)
            3'h0:    return 5'h00;
            3'h1:    return 5'h01;
            3'h2:    return 5'h02;
            3'h3:    return 5'h04;
            3'h4:    return 5'h08;
            3'h5:    return 5'h10;
            3'h6:    return 5'h18;
            default: return 5'h1F;
        endcase
    endfunction

endpackage

// [logic/lbsc_top.sv]
// I2C single-channel and broadcast command decoder with per-channel mode registers and fade
`timescale 1ns/100ps
module lbsc_top
    import lbsc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [3:0]  address_strap_pins,
    input  wire logic        alert_active,
    input  wire logic        pwm_clk_in,
    output logic [7:0]       open_threshold_select,
    output logic [7:0]       short_threshold_select,
    output logic [7:0]       async_enable,
    output logic [7:0]       async_on_off,
    output logic [7:0]       fade_done_flag,
    output logic [63:0]      dimming_level,
    output logic             pwm_counter_restart,
    output logic             pwm_source_clock,
    output logic             alert_response_done
);

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [3:0]  strap_s1, strap_s2;
    logic        scl_s1, scl_s2, scl_d;
    logic        sda_s1, sda_s2, sda_d;
    logic        alert_s1, alert_s2;
    logic        pclk_s1, pclk_s2, pclk_d;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strap_s1 <= 4'h0;
            strap_s2 <= 4'h0;
            scl_s1   <= 1'b1;
            scl_s2   <= 1'b1;
            scl_d    <= 1'b1;
            sda_s1   <= 1'b1;
            sda_s2   <= 1'b1;
            sda_d    <= 1'b1;
            alert_s1 <= 1'b0;
            alert_s2 <= 1'b0;
            pclk_s1  <= 1'b0;
            pclk_s2  <= 1'b0;
            pclk_d   <= 1'b0;
        end else begin
            strap_s1 <= address_strap_pins;
            strap_s2 <= strap_s1;
            scl_s1   <= scl_in;
            scl_s2   <= scl_s1;
            scl_d    <= scl_s2;
            sda_s1   <= sda_in;
            sda_s2   <= sda_s1;
            sda_d    <= sda_s2;
            alert_s1 <= alert_active;
            alert_s2 <= alert_s1;
            pclk_s1  <= pwm_clk_in;
            pclk_s2  <= pclk_s1;
            pclk_d   <= pclk_s2;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det, pclk_rise;
    assign scl_rise  = scl_s2 & ~scl_d;
    assign scl_fall  = ~scl_s2 & scl_d;
    assign start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
    assign stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;
    assign pclk_rise = pclk_s2 & ~pclk_d;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [15:0] mode_reg [8];
    logic [15:0] pend_word [8];
    logic [7:0]  pend_valid;
    logic [7:0]  level_reg [8];
    logic [4:0]  step_cnt [8];
    logic [7:0]  done_reg;
    logic [2:0]  sel_ch_reg;

    // ------------------------------------------------------------
    // Bus state machine
    // ------------------------------------------------------------
    lbsc_state_e state;
    lbsc_kind_e  kind;
    logic [2:0]  bit_cnt;
    logic [2:0]  byte_idx;
    logic [1:0]  tx_idx;
    logic [6:0]  shift_reg;
    logic [7:0]  crc_reg;
    logic [7:0]  addr_reg;
    logic [7:0]  cmd_reg;
    logic [7:0]  dim_reg;
    logic [7:0]  rd_b1, rd_b2;
    logic        ack_ok;
    logic        pec_good;
    logic        pec_ok;
    logic        bc_pulse;
    logic        ara_pulse;
    logic        drive_low;

    logic [7:0]  rx_byte;
    logic [7:0]  rd_crc;
    logic [7:0]  tx_byte;
    logic [15:0] sel_word;
    assign rx_byte  = {shift_reg, sda_s2};
    assign sel_word = mode_reg[sel_ch_reg];
    assign rd_crc   = lbsc_crc8(lbsc_crc8(lbsc_crc8(8'h00, addr_reg), rd_b1), rd_b2);

    always_comb begin
        if (kind == K_BC_RD) begin
            tx_byte = {ARA_REPLY_PFX, strap_s2, 1'b1};
        end else begin
            case (tx_idx)
                2'h0:    tx_byte = rd_b1;
                2'h1:    tx_byte = rd_b2;
                default: tx_byte = rd_crc;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state     <= ST_IDLE;
            kind      <= K_SC_WR;
            bit_cnt   <= 3'h0;
            byte_idx  <= 3'h0;
            tx_idx    <= 2'h0;
            shift_reg <= 7'h00;
            crc_reg   <= 8'h00;
            addr_reg  <= 8'h00;
            cmd_reg   <= 8'h00;
            dim_reg   <= 8'h00;
            rd_b1     <= 8'h00;
            rd_b2     <= 8'h00;
            ack_ok    <= 1'b0;
            pec_good  <= 1'b0;
            pec_ok    <= 1'b0;
            bc_pulse  <= 1'b0;
            ara_pulse <= 1'b0;
            drive_low <= 1'b0;
        end else begin
            pec_ok    <= 1'b0;
            bc_pulse  <= 1'b0;
            ara_pulse <= 1'b0;
            if (start_det) begin
                state     <= ST_RX;
                bit_cnt   <= 3'h0;
                byte_idx  <= 3'h0;
                tx_idx    <= 2'h0;
                crc_reg   <= 8'h00;
                drive_low <= 1'b0;
            end else if (stop_det) begin
                state     <= ST_IDLE;
                drive_low <= 1'b0;
            end else begin
                case (state)
                    ST_RX: begin
                        if (scl_rise) begin
                            shift_reg <= rx_byte[6:0];
                            bit_cnt   <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                state    <= ST_ACK;
                                pec_good <= 1'b0;
                                if (byte_idx == 3'h0) begin
                                    addr_reg <= rx_byte;
                                    crc_reg  <= lbsc_crc8(8'h00, rx_byte);
                                    rd_b1    <= {sel_word[15:11], done_reg[sel_ch_reg], sel_word[9:8]};
                                    rd_b2    <= sel_word[7:0];
                                    if (rx_byte[7:1] == {SC_ADDR_PREFIX, strap_s2}) begin
                                        kind   <= rx_byte[0] ? K_SC_RD : K_SC_WR;
                                        ack_ok <= 1'b1;
                                    end else if (rx_byte == BC_WRITE_ADDR) begin
                                        kind   <= K_BC_WR;
                                        ack_ok <= 1'b1;
                                    end else if (rx_byte == BC_READ_ADDR) begin
                                        kind   <= K_BC_RD;
                                        ack_ok <= alert_s2;
                                    end else begin
                                        ack_ok <= 1'b0;
                                    end
                                end else if (kind == K_SC_WR && byte_idx == 3'h1) begin
                                    cmd_reg <= rx_byte;
                                    crc_reg <= lbsc_crc8(crc_reg, rx_byte);
                                    ack_ok  <= 1'b1;
                                end else if (kind == K_SC_WR && byte_idx == SHORT_PEC_IDX && cmd_reg[CMD_LONG_BIT]) begin
                                    dim_reg <= rx_byte;
                                    crc_reg <= lbsc_crc8(crc_reg, rx_byte);
                                    ack_ok  <= 1'b1;
                                end else if (kind == K_SC_WR &&
                                             byte_idx == (cmd_reg[CMD_LONG_BIT] ? LONG_PEC_IDX : SHORT_PEC_IDX)) begin
                                    ack_ok   <= (rx_byte == crc_reg);
                                    pec_good <= (rx_byte == crc_reg);
                                end else begin
                                    ack_ok <= 1'b0;
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            drive_low <= ack_ok;
                            pec_ok    <= pec_good;
                            bc_pulse  <= ack_ok && kind == K_BC_WR && byte_idx == 3'h0;
                            state     <= ack_ok ? ST_ACKHOLD : ST_IGNORE;
                        end
                    end
                    ST_ACKHOLD: begin
                        if (scl_fall) begin
                            byte_idx <= (byte_idx == 3'h7) ? byte_idx : byte_idx + 3'h1;
                            bit_cnt  <= 3'h0;
                            if (kind == K_SC_RD || kind == K_BC_RD) begin
                                drive_low <= ~tx_byte[7];
                                state     <= ST_TX;
                            end else begin
                                drive_low <= 1'b0;
                                state     <= ST_RX;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise && kind == K_BC_RD && !drive_low && !sda_s2) begin
                            state <= ST_IGNORE; // Lost arbitration to a lower address
                        end else if (scl_fall) begin
                            if (bit_cnt == 3'h7) begin
                                drive_low <= 1'b0;
                                state     <= ST_TXACK;
                            end else begin
                                bit_cnt   <= bit_cnt + 3'h1;
                                drive_low <= ~tx_byte[3'h6 - bit_cnt];
                            end
                        end
                    end
                    ST_TXACK: begin
                        // Master acknowledge is optional, so it is not inspected
                        if (scl_fall) begin
                            bit_cnt <= 3'h0;
                            if (kind == K_BC_RD) begin
                                ara_pulse <= 1'b1;
                                state     <= ST_IGNORE;
                            end else if (tx_idx == READ_LAST_IDX) begin
                                state <= ST_IGNORE;
                            end else begin
                                tx_idx    <= tx_idx + 2'h1;
                                drive_low <= ~((tx_idx == 2'h0) ? rd_b2[7] : rd_crc[7]);
                                state     <= ST_TX;
                            end
                        end
                    end
                    ST_IGNORE: begin
                        drive_low <= 1'b0;
                    end
                    default: begin
                        state     <= ST_IDLE;
                        drive_low <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = drive_low;

    // ------------------------------------------------------------
    // Holding latches and mode registers
    // ------------------------------------------------------------
    logic [2:0]  wr_ch;
    logic [15:0] merged;
    assign wr_ch = cmd_reg[6:4];

    always_comb begin
        merged = pend_valid[wr_ch] ? pend_word[wr_ch] : mode_reg[wr_ch];
        if (!cmd_reg[CMD_LONG_BIT]) begin
            merged[MR_OPEN_THR]  = cmd_reg[3];
            merged[MR_SHORT_THR] = cmd_reg[2];
            merged[MR_ASYNC_ON]  = cmd_reg[1];
            merged[MR_ASYNC_EN]  = cmd_reg[0];
            if (cmd_reg[0]) begin
                merged[7:0] = {8{cmd_reg[1]}};
            end
        end else begin
            merged[MR_FADE_HI:MR_FADE_LO] = cmd_reg[3:1];
            merged[MR_ASYNC_EN]           = cmd_reg[0];
            merged[7:0]                   = dim_reg;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                mode_reg[i]  <= MR_RESET;
                pend_word[i] <= MR_RESET;
            end
            pend_valid <= 8'h00;
            sel_ch_reg <= 3'h0;
        end else if (pec_ok) begin
            pend_word[wr_ch]  <= merged;
            pend_valid[wr_ch] <= 1'b1;
            sel_ch_reg        <= wr_ch;
            if (!cmd_reg[CMD_LONG_BIT]) begin
                mode_reg[wr_ch][MR_OPEN_THR:MR_SHORT_THR] <= cmd_reg[3:2];
            end
        end else if (stop_det) begin
            // Every pending channel lands on the same edge
            for (int i = 0; i < 8; i++) begin
                if (pend_valid[i]) begin
                    mode_reg[i] <= pend_word[i];
                end
            end
            pend_valid <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // PWM cycle counter and broadcast pulses
    // ------------------------------------------------------------
    logic [10:0] pwm_cnt;
    logic        pwm_tick;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwm_cnt             <= 11'h000;
            pwm_tick            <= 1'b0;
            pwm_counter_restart <= 1'b0;
            pwm_source_clock    <= 1'b0;
            alert_response_done <= 1'b0;
        end else begin
            pwm_counter_restart <= bc_pulse;
            pwm_source_clock    <= bc_pulse;
            alert_response_done <= ara_pulse;
            pwm_tick            <= pclk_rise && pwm_cnt == PWM_CNT_LAST;
            if (bc_pulse) begin
                pwm_cnt <= 11'h000;
            end else if (pclk_rise) begin
                pwm_cnt <= pwm_cnt + 11'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // Fade engine
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                level_reg[i] <= 8'h00;
                step_cnt[i]  <= 5'h00;
            end
            done_reg <= 8'hFF;
        end else begin
            for (int i = 0; i < 8; i++) begin
                done_reg[i] <= (level_reg[i] == mode_reg[i][7:0]);
                if (lbsc_fade_mult(mode_reg[i][MR_FADE_HI:MR_FADE_LO]) == 5'h00) begin
                    level_reg[i] <= mode_reg[i][7:0];
                    step_cnt[i]  <= 5'h00;
                end else if (level_reg[i] != mode_reg[i][7:0] && pwm_tick) begin
                    if (step_cnt[i] + 5'h01 >= lbsc_fade_mult(mode_reg[i][MR_FADE_HI:MR_FADE_LO])) begin
                        step_cnt[i]  <= 5'h00;
                        level_reg[i] <= (level_reg[i] < mode_reg[i][7:0]) ? level_reg[i] + 8'h01
                                                                         : level_reg[i] - 8'h01;
                    end else begin
                        step_cnt[i] <= step_cnt[i] + 5'h01;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Channel outputs
    // ------------------------------------------------------------
    // Async bits go straight out so forcing ignores the dimming cycle
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            open_threshold_select[i]  = mode_reg[i][MR_OPEN_THR];
            short_threshold_select[i] = mode_reg[i][MR_SHORT_THR];
            async_enable[i]           = mode_reg[i][MR_ASYNC_EN];
            async_on_off[i]           = mode_reg[i][MR_ASYNC_ON];
            dimming_level[i*8 +: 8]   = level_reg[i];
        end
    end
    assign fade_done_flag = done_reg;

endmodule // lbsc_top

// [testbench/lbsc_monitor.sv]
// Checker of the decoder's bus timing and event pulses
`timescale 1ns/100ps
module lbsc_monitor (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_oe,
    input wire logic       alert_active,
    input wire logic [7:0] open_threshold_select,
    input wire logic [7:0] short_threshold_select,
    input wire logic [7:0] async_enable,
    input wire logic [7:0] async_on_off,
    input wire logic       pwm_counter_restart,
    input wire logic       pwm_source_clock,
    input wire logic       alert_response_done
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // ------------------
    // Assertions
    // ------------------
    chk_restart_pair: assert property (pwm_counter_restart == pwm_source_clock)
        else $error("restart and source pulses differ");
    chk_restart_pulse: assert property (pwm_counter_restart |=> !pwm_counter_restart)
        else $error("restart pulse too long");
    chk_restart_slot: assert property (pwm_counter_restart |-> !scl_in)
        else $error("restart outside ack slot");
    chk_bcast_keeps: assert property (pwm_counter_restart |-> $stable(async_enable)
        && $stable(open_threshold_select)) else $error("broadcast changed a register");
    chk_thr_at_ack: assert property ($changed(open_threshold_select) || $changed(short_threshold_select)
        |-> !scl_in) else $error("threshold moved outside pec ack");
    chk_async_at_stop: assert property ($changed(async_enable) || $changed(async_on_off)
        |-> scl_in && sda_in) else $error("async bits moved before stop");
    chk_alert_pin: assert property (alert_response_done |-> alert_active)
        else $error("alert reply without alert");
    chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda drive changed while scl high");
    chk_oe_holds: assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("sda low too short");
    cover property (pwm_counter_restart);
    cover property (alert_response_done);
    cover property ($changed(async_enable));
endmodule // lbsc_monitor

bind lbsc_top lbsc_monitor i_lbsc_monitor (.*);

// [testbench/lbsc_i2c_master.sv]
// I2C master model driving the decoder's bus pins
`timescale 1ns/100ps
module lbsc_i2c_master (
    input  wire logic ref_clk,
    input  wire logic sda_oe,
    output logic      scl,
    output wire logic sda
);
    logic rel = 1'b1;
    initial scl = 1'b1;
    // Pull-up wins unless the master or the device pulls low
    assign sda = rel & ~sda_oe;
    // ------------------
    // Bus phases
    // ------------------
    // Six cycles a phase, well above the decoder's sync delay
    task automatic ph(input logic s, input logic r);
        @(posedge ref_clk);
        scl <= s;
        rel <= r;
        repeat (5) @(posedge ref_clk);
    endtask
    task automatic start();
        ph(1'b0, rel);
        ph(1'b0, 1'b1);
        ph(1'b1, 1'b1);
        ph(1'b1, 1'b0);
    endtask
    task automatic stop();
        ph(1'b0, rel);
        ph(1'b0, 1'b0);
        ph(1'b1, 1'b0);
        ph(1'b1, 1'b1);
    endtask
    // Only single-channel and broadcast traffic, never multi-switch writes
    task automatic xb(input logic [7:0] b, output logic [7:0] r, output logic ack);
        logic [8:0] v;
        v = {b, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            ph(1'b0, rel);
            ph(1'b0, v[i]);
            ph(1'b1, v[i]);
            v[i] = sda;
        end
        r = v[8:1];
        ack = ~v[0];
    endtask
endmodule // lbsc_i2c_master

// [testbench/test_led_bypass_i2c_channel_commands.sv]
// Self-checking bench for the LED bypass command decoder
`timescale 1ns/100ps
module test_led_bypass_i2c_channel_commands;
    logic        ref_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        alert   = 1'b0;
    logic        pwm_clk = 1'b0;
    logic [3:0]  straps;
    logic        scl, oe, ad, rs;
    wire logic   sda;
    logic [7:0]  ots, sts, ase, aso, fdf;
    logic [63:0] dl;
    logic [15:0] mr [8];
    logic [2:0]  mch = 3'h0;
    int          fail_count = 0, tests_run = 0, n_rs = 0, n_ad = 0;

    lbsc_top i_lbsc_top (.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(oe),
        .address_strap_pins(straps), .alert_active(alert), .pwm_clk_in(pwm_clk), .open_threshold_select(ots),
        .short_threshold_select(sts), .async_enable(ase), .async_on_off(aso), .fade_done_flag(fdf),
        .dimming_level(dl), .pwm_counter_restart(rs), .pwm_source_clock(), .alert_response_done(ad));
    lbsc_i2c_master i_m (.ref_clk(ref_clk), .sda_oe(oe), .scl(scl), .sda(sda));

    initial forever #10 ref_clk = ~ref_clk;
    initial begin
        #37;
        forever #80 pwm_clk = ~pwm_clk;
    end
    always @(posedge ref_clk) begin
        n_rs += int'(rs);
        n_ad += int'(ad);
    end
    // ------------------
    // Model and helpers
    // ------------------
    function automatic logic [7:0] crc(input logic [7:0] q[$]);
        logic [7:0] c = 8'h00;
        foreach (q[i]) begin
            c ^= q[i];
            repeat (8)
                c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic cmp_all();
        for (int c = 0; c < 8; c++) begin
            chk("open_thr", ots[c], mr[c][15]);
            chk("short_thr", sts[c], mr[c][14]);
            chk("async_on", aso[c], mr[c][9]);
            chk("async_en", ase[c], mr[c][8]);
            chk("level", dl[8*c+:8], mr[c][7:0]);
        end
    endtask
    task automatic fin();
        i_m.stop();
        repeat (8) @(posedge ref_clk);
        cmp_all();
    endtask
    task automatic adr(input logic [7:0] b, input logic ex);
        logic [7:0] r;
        logic       a;
        i_m.xb(b, r, a);
        chk("ack", a, ex);
    endtask
    task automatic scw(input logic [2:0] ch, input logic [3:0] cf, input logic lg, input logic [7:0] dm,
                       input logic bad);
        logic [7:0] q[$];
        q.push_back({3'h5, straps, 1'b0});
        q.push_back({lg, ch, cf});
        if (lg)
            q.push_back(dm);
        q.push_back(crc(q) ^ {7'h00, bad});
        i_m.start();
        foreach (q[i])
            adr(q[i], i < q.size() - 1 || !bad);
        if (!bad) begin
            mch = ch;
            if (lg)
                mr[ch] = {mr[ch][15:14], cf[3:1], mr[ch][10:9], cf[0], dm};
            else
                mr[ch] = {cf[3:2], mr[ch][13:10], cf[1:0], cf[0] ? {8{cf[1]}} : mr[ch][7:0]};
        end
    endtask
    task automatic rdchk();
        logic [7:0] q[$];
        logic [7:0] r;
        logic       a;
        q.push_back({3'h5, straps, 1'b1});
        i_m.start();
        adr(q[0], 1'b1);
        for (int k = 0; k < 3; k++) begin
            i_m.xb(8'hFF, r, a);
            q.push_back(r);
        end
        fin();
        chk("read_cfg", q[1], {mr[mch][15:11], 1'b1, mr[mch][9:8]});
        chk("read_dim", q[2], mr[mch][7:0]);
        chk("read_pec", q[3], crc(q[0:2]));
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ------------------
    // Main sequence
    // ------------------
    initial begin
        logic [7:0]  r, dm;
        logic        a;
        logic [2:0]  ch;
        logic [3:0]  cf;
        logic [15:0] p;
        int          k;
        void'($urandom(32'h48ea));
        straps = 4'($urandom);
        foreach (mr[c])
            mr[c] = 16'h8000;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        cmp_all();
        rdchk();
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            ch = 3'($urandom);
            cf = 4'($urandom);
            dm = 8'($urandom);
            if (i[0]) begin
                cf[3:1] = 3'(i >> 1);
                if (cf[3:1] != 3'h0)
                    dm = mr[ch][7:0];
            end
            else if (mr[ch][13:11] != 3'h0)
                cf[0] = 1'b0;
            p = mr[ch];
            scw(ch, cf, i[0], dm, 1'b0);
            chk("thr_early", {ots[ch], sts[ch]}, mr[ch][15:14]);
            chk("async_held", ase[ch], p[8]);
            fin();
            rdchk();
        end
        $display("write test done");
        scw(3'($urandom), 4'($urandom), 1'b0, 8'h00, 1'b1);
        fin();
        i_m.start();
        adr({3'h5, ~straps, 1'b0}, 1'b0);
        fin();
        straps <= ~straps;
        @(posedge ref_clk);
        rdchk();
        $display("refusal test done");
        i_m.start();
        adr(8'h18, 1'b1);
        fin();
        chk("restart", n_rs, 1);
        i_m.start();
        adr(8'h19, 1'b0);
        fin();
        alert <= 1'b1;
        i_m.start();
        adr(8'h19, 1'b1);
        i_m.xb(8'hFF, r, a);
        fin();
        chk("alert_reply", r, {3'h2, straps, 1'b1});
        chk("alert_done", n_ad, 1);
        alert <= 1'b0;
        $display("broadcast test done");
        ch = mch;
        p = mr[ch];
        dm = p[7:0] ^ 8'h01;
        scw(ch, 4'h4, 1'b1, dm, 1'b0);
        i_m.stop();
        repeat (8) @(posedge ref_clk);
        chk("fade_busy", fdf[ch], 1'b0);
        chk("fade_hold", dl[8*ch+:8], p[7:0]);
        for (k = 0; k < 40000 && dl[8*ch+:8] !== dm; k++)
            @(posedge ref_clk);
        repeat (2) @(posedge ref_clk);
        chk("fade_end", dl[8*ch+:8], dm);
        chk("fade_time", k > 16370 && k <= 32780, 1'b1);
        chk("fade_flag", fdf[ch], 1'b1);
        $display("fade test done");
        end_sim();
    end
endmodule // test_led_bypass_i2c_channel_commands
